// ===== hdl/rstcause_pkg.sv
/*
  constants for the reset-cause and watchdog block: register offsets,
  bit positions of the reset control register, vectors and timing counts.
  assumes a 125 MHz system clock and a 32-bit classic wishbone bus.
*/
package rstcause_pkg;
  // byte offsets on the register bus
  localparam logic [7:0] CTRL_OFS = 8'h00;  // reset control register
  localparam logic [7:0] FUSE_OFS = 8'h04;  // watchdog config word (fuse image)
  localparam logic [7:0] PC_OFS = 8'h08;    // last vector loaded
  localparam logic [7:0] WDT_OFS = 8'h0C;   // watchdog count, read only

  // bit positions of the reset control register
  localparam int POR_BIT = 0;
  localparam int BOR_BIT = 1;
  localparam int IDLE_BIT = 2;
  localparam int SLEEP_BIT = 3;
  localparam int WATCHDOG_TIMEOUT_FLAG_BIT = 4;
  localparam int SWEN_BIT = 5;
  localparam int SWR_BIT = 6;
  localparam int EXTERNAL_RESET_FLAG_BIT = 7;
  localparam int LVL_LSB = 8;
  localparam int LVEN_BIT = 12;
  localparam int REFERENCE_STABLE_FLAG_BIT = 13;
  localparam int IOP_BIT = 14;
  localparam int TRAP_BIT = 15;

  // writable bits: everything but the reference-stable flag
  localparam logic [15:0] CTRL_WMASK = 16'hDFFF;
  localparam logic [15:0] CTRL_RESET = 16'h0003;

  // program counter values
  localparam logic [23:0] RESET_VEC = 24'h000000;
  localparam logic [23:0] CLKFAIL_VEC = 24'h000004;
  localparam logic [23:0] PC_STEP = 24'h000002;

  // watchdog: counter width, fuse reset value (erased fuse reads 1)
  localparam int WDT_W = 16;
  localparam logic FUSE_RESET = 1'b1;

  // reference settle time in ns and its cycle count (least time, rounded up)
  localparam int CLK_NS = 8;
  localparam int BG_SETTLE_NS = 1000;
  localparam int BG_CYCLES = (BG_SETTLE_NS + CLK_NS - 1) / CLK_NS;
endpackage

// ===== hdl/reset_cause_and_watchdog.sv
/*
  reset-cause recording, watchdog and low-voltage detector control.
  assumes: reset/wake events arrive as one-cycle pulses from logic on i_clk,
  the master-clear pin and the rc-oscillator tick come from outside and are
  synchronised here; software reaches the registers over classic wishbone.
*/
// The implementer's own choices: the placing of the registers and register access over Wishbone.
// What this block does
// RQ1: every reset loads pc zero; clock-fail trap vectors to four, flags untouched
// RQ2: power-on sets power-on and brown-out flags, clears all others
// RQ3: brown-out sets brown-out flag, clears power-on, others unchanged
// RQ4: master clear while running sets external, clears soft, watchdog, idle, sleep
// RQ5: soft reset sets soft flag, clears external, watchdog, idle, sleep
// RQ6: master clear in sleep sets external and sleep, clears watchdog and idle
// RQ7: master clear in idle sets external and idle, clears watchdog and sleep
// RQ8: watchdog timeout when awake resets, sets watchdog, clears external, soft, idle, sleep
// RQ9: watchdog timeout in sleep wakes at pc+2, sets watchdog and sleep flags
// RQ10: interrupt wake from sleep sets sleep flag, continues at pc+2 or vector
// RQ11: trap conflict and illegal op resets set their own flag, pc zero
// RQ12: all reset-cause flags are software readable and writable
// RQ13: watchdog counts on rc oscillator ticks, independent of the cpu clock
// RQ14: enabled watchdog increments until overflow, which is the timeout
// RQ15: fuse enable of one forces watchdog on; fuse reads one after erase
// RQ16: with fuse zero the soft enable bit five gates the watchdog
// RQ17: watchdog clear instruction resets the count; software must issue it
// RQ18: detector threshold comes from the 4-bit level field, bits 11 to 8
// RQ19: detector runs only while its enable bit twelve is set
// RQ20: read-only bit thirteen shows the reference has settled after enable
// RQ21: power-save instruction operand picks sleep or idle
// RQ22: internal resets never drive the master-clear pin low
// RQ23: brown-out flag sits at bit one
// RQ24: reference-stable flag clears whenever the detector is disabled
`timescale 1ns/1ps
module reset_cause_and_watchdog (
  input wire logic i_clk,
  input wire logic i_rstn,
  // classic wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [3:0] i_wb_sel,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // event pulses from on-chip logic
  input wire logic i_por_evt,
  input wire logic i_bor_evt,
  input wire logic i_swr_evt,
  input wire logic i_trap_conflict_evt,
  input wire logic i_illegal_op_evt,
  input wire logic i_clkfail_evt,
  input wire logic i_irq_wake_evt,
  input wire logic i_watchdog_clear_instr,
  input wire logic i_power_save_instr,
  input wire logic i_power_save_idle,
  input wire logic [23:0] i_cur_pc,
  // asynchronous inputs
  input wire logic i_master_clear_pin_n,
  input wire logic i_rc_tick,
  // master-clear pin: open-drain output, never driven by this block
  output logic o_master_clear_pin_out,
  output logic o_master_clear_pin_oe,
  // results
  output logic o_sys_reset,
  output logic o_pc_load,
  output logic [23:0] o_pc_value,
  output logic o_sleeping,
  output logic o_idling,
  output logic o_lowvolt_detect_enable,
  output logic [3:0] o_lowvolt_level_sel
);

  // width is taken from the package so the count and its read-back agree
  localparam int WDT_W_LOCAL = rstcause_pkg::WDT_W;

  // power state of the core; only the save instruction leaves run
  typedef enum logic [1:0] {RUN, SLEEP, IDLE} power_e;

  // reset release pair
  logic rst_meta_reg, rst_sync_reg;
  // pin and rc tick synchroniser stages plus the edge-detect history
  logic master_clear_pin_meta_reg, master_clear_pin_sync_reg, master_clear_pin_last_reg;
  logic tick_meta_reg, tick_sync_reg, tick_last_reg;
  // software-visible state
  logic [15:0] reset_control_reg, reset_control_next;
  logic watchdog_config_word_reg;
  // watchdog and reference settle counters
  logic [WDT_W_LOCAL-1:0] wdt_count_reg;
  logic [7:0] bg_count_reg;
  // power state and its registered output copies
  power_e power_reg;
  logic sleeping_reg, idling_reg;
  // vector and result pulses
  logic [23:0] pc_reg;
  logic pc_load_reg, sys_reset_reg, ack_reg;
  // bus read data, valid while ack stands
  logic [31:0] rdat_reg;

  // reset release through two flops; assert is asynchronous
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  wire rstn = rst_sync_reg;

  // pin and rc tick synchronisers; only the second stage and the history flop feed logic
  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      master_clear_pin_meta_reg <= 1'b1;
      master_clear_pin_sync_reg <= 1'b1;
      master_clear_pin_last_reg <= 1'b1;
      tick_meta_reg <= 1'b0;
      tick_sync_reg <= 1'b0;
      tick_last_reg <= 1'b0;
    end else begin
      master_clear_pin_meta_reg <= i_master_clear_pin_n;
      master_clear_pin_sync_reg <= master_clear_pin_meta_reg;
      master_clear_pin_last_reg <= master_clear_pin_sync_reg;
      tick_meta_reg <= i_rc_tick;
      tick_sync_reg <= tick_meta_reg;
      tick_last_reg <= tick_sync_reg;
    end
  end

  // edge detectors read only the second stage and the history flop;
  // their history resets to the idle level of each pin, so the release
  // of reset never looks like an edge.
  // limitation: a pin pulse shorter than one clock period may be missed,
  // which also acts as a crude filter against narrow glitches.
  wire master_clear_pin_evt = master_clear_pin_last_reg & ~master_clear_pin_sync_reg;  // falling edge of the pin
  wire rc_en = tick_sync_reg & ~tick_last_reg;     // one pulse per rc period

  // bus decode; a one-cycle ack, dropped the cycle after it is given
  wire bus_req = i_wb_cyc & i_wb_stb & ~ack_reg;
  wire wr_ctrl = bus_req & i_wb_we & (i_wb_adr == rstcause_pkg::CTRL_OFS);
  wire wr_fuse = bus_req & i_wb_we & (i_wb_adr == rstcause_pkg::FUSE_OFS);

  // byte-lane merge of a bus write into the 16-bit control word;
  // lanes 2 and 3 fall outside the register and are dropped
  function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                             input logic [31:0] dat,
                                             input logic [3:0] sel);
    lane_merge = old;
    if (sel[0]) lane_merge[7:0] = dat[7:0];
    if (sel[1]) lane_merge[15:8] = dat[15:8];
  endfunction

  // watchdog enable: forced by fuse, else the soft bit
  wire wdt_en = watchdog_config_word_reg |
                reset_control_reg[rstcause_pkg::SWEN_BIT];  // see RQ15 see RQ16
  wire wdt_ovf = wdt_en & rc_en & (&wdt_count_reg);  // see RQ14
  wire wdt_reset = wdt_ovf & (power_reg != SLEEP);    // see RQ8
  wire wdt_wake = wdt_ovf & (power_reg == SLEEP);     // see RQ9
  // master clear while running also clears the soft-reset flag;
  // from sleep or idle that flag is kept
  wire master_clear_pin_run = master_clear_pin_evt & (power_reg == RUN);
  // every source that restarts the core at the reset vector
  wire any_reset = i_por_evt | i_bor_evt | master_clear_pin_evt | i_swr_evt | wdt_reset |
                   i_trap_conflict_evt | i_illegal_op_evt;

  // next flag value: software write first, events on top so a set wins.
  // only one event is applied per cycle; the priority chain below is
  // por, bor, master clear, watchdog reset, soft reset, trap, illegal op,
  // watchdog wake and interrupt wake. a lower event lost in a collision
  // is not remembered, since a higher reset restarts the core anyway.
  // the reference-stable bit is recomputed last so no write can set it.
  always_comb begin
    reset_control_next = reset_control_reg;
    if (wr_ctrl) begin  // see RQ12
      reset_control_next = (lane_merge(reset_control_reg, i_wb_dat, i_wb_sel) &
                            rstcause_pkg::CTRL_WMASK) |
                           (reset_control_reg & ~rstcause_pkg::CTRL_WMASK);
    end
    if (i_por_evt) begin
      // flags cleared, power-on and brown-out set; control fields kept
      reset_control_next[rstcause_pkg::TRAP_BIT] = 1'b0;  // see RQ2
      reset_control_next[rstcause_pkg::IOP_BIT] = 1'b0;
      reset_control_next[rstcause_pkg::EXTERNAL_RESET_FLAG_BIT] = 1'b0;
      reset_control_next[rstcause_pkg::SWR_BIT] = 1'b0;
      reset_control_next[rstcause_pkg::WATCHDOG_TIMEOUT_FLAG_BIT] = 1'b0;
      reset_control_next[rstcause_pkg::IDLE_BIT] = 1'b0;
      reset_control_next[rstcause_pkg::SLEEP_BIT] = 1'b0;
      reset_control_next[rstcause_pkg::POR_BIT] = 1'b1;
      reset_control_next[rstcause_pkg::BOR_BIT] = 1'b1;  // see RQ23
    end else if (i_bor_evt) begin
      reset_control_next[rstcause_pkg::POR_BIT] = 1'b0;  // see RQ3
      reset_control_next[rstcause_pkg::BOR_BIT] = 1'b1;
    end else if (master_clear_pin_evt) begin
      reset_control_next[rstcause_pkg::EXTERNAL_RESET_FLAG_BIT] = 1'b1;  // see RQ4
      reset_control_next[rstcause_pkg::WATCHDOG_TIMEOUT_FLAG_BIT] = 1'b0;
      reset_control_next[rstcause_pkg::IDLE_BIT] = (power_reg == IDLE);   // see RQ7
      reset_control_next[rstcause_pkg::SLEEP_BIT] = (power_reg == SLEEP); // see RQ6
      if (master_clear_pin_run) reset_control_next[rstcause_pkg::SWR_BIT] = 1'b0;
    end else if (wdt_reset) begin
      reset_control_next[rstcause_pkg::WATCHDOG_TIMEOUT_FLAG_BIT] = 1'b1;  // see RQ8
      reset_control_next[rstcause_pkg::EXTERNAL_RESET_FLAG_BIT] = 1'b0;
      reset_control_next[rstcause_pkg::SWR_BIT] = 1'b0;
      reset_control_next[rstcause_pkg::IDLE_BIT] = 1'b0;
      reset_control_next[rstcause_pkg::SLEEP_BIT] = 1'b0;
    end else if (i_swr_evt) begin
      reset_control_next[rstcause_pkg::SWR_BIT] = 1'b1;  // see RQ5
      reset_control_next[rstcause_pkg::EXTERNAL_RESET_FLAG_BIT] = 1'b0;
      reset_control_next[rstcause_pkg::WATCHDOG_TIMEOUT_FLAG_BIT] = 1'b0;
      reset_control_next[rstcause_pkg::IDLE_BIT] = 1'b0;
      reset_control_next[rstcause_pkg::SLEEP_BIT] = 1'b0;
    end else if (i_trap_conflict_evt) begin
      reset_control_next[rstcause_pkg::TRAP_BIT] = 1'b1;  // see RQ11
    end else if (i_illegal_op_evt) begin
      reset_control_next[rstcause_pkg::IOP_BIT] = 1'b1;  // see RQ11
    end else if (wdt_wake) begin
      reset_control_next[rstcause_pkg::WATCHDOG_TIMEOUT_FLAG_BIT] = 1'b1;  // see RQ9
      reset_control_next[rstcause_pkg::SLEEP_BIT] = 1'b1;
    end else if (i_irq_wake_evt && power_reg == SLEEP) begin
      reset_control_next[rstcause_pkg::SLEEP_BIT] = 1'b1;  // see RQ10
    end
    // clock-fail trap touches no flag (see RQ1)
    // reference-stable flag is hardware only; cleared while detector is off
    reset_control_next[rstcause_pkg::REFERENCE_STABLE_FLAG_BIT] =
      reset_control_next[rstcause_pkg::LVEN_BIT] &
      (bg_count_reg == 8'(rstcause_pkg::BG_CYCLES));  // see RQ20 see RQ24
  end

  // reset control register; after reset it shows power-on and brown-out
  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      reset_control_reg <= rstcause_pkg::CTRL_RESET;
    end else begin
      reset_control_reg <= reset_control_next;
    end
  end

  // fuse image: erased value one, rewritable by the programming path.
  // trade-off: a real fuse survives reset; here the image reloads its
  // erased value, which is the safe side since the watchdog comes up on.
  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      watchdog_config_word_reg <= rstcause_pkg::FUSE_RESET;  // see RQ15
    end else if (wr_fuse && i_wb_sel[0]) begin
      watchdog_config_word_reg <= i_wb_dat[0];
    end
  end

  // watchdog counter advances only on rc ticks, so a stalled cpu clock
  // elsewhere does not stop it; clear on instruction or any reset.
  // the overflow cycle itself clears the count, so a sleep wake starts
  // a fresh period. a disabled watchdog holds zero, so enabling it never
  // inherits a partly run period.
  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      wdt_count_reg <= '0;
    end else if (i_watchdog_clear_instr || any_reset || wdt_ovf || !wdt_en) begin
      wdt_count_reg <= '0;  // see RQ17
    end else if (rc_en) begin
      wdt_count_reg <= wdt_count_reg + 1'b1;  // see RQ13 see RQ14
    end
  end

  // reference settle counter runs from detector enable, held at terminal;
  // a disable restarts it so every enable waits a full settle interval
  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      bg_count_reg <= '0;
    end else if (!reset_control_reg[rstcause_pkg::LVEN_BIT]) begin
      bg_count_reg <= '0;  // see RQ24
    end else if (bg_count_reg != 8'(rstcause_pkg::BG_CYCLES)) begin
      bg_count_reg <= bg_count_reg + 8'h01;
    end
  end

  // power state: the instruction operand picks sleep or idle.
  // the output copies are kept in step here so the pins come from flops
  // with the same timing as the state itself.
  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      power_reg <= RUN;
      sleeping_reg <= 1'b0;
      idling_reg <= 1'b0;
    end else if (any_reset || wdt_wake || i_irq_wake_evt) begin
      power_reg <= RUN;
      sleeping_reg <= 1'b0;
      idling_reg <= 1'b0;
    end else if (i_power_save_instr && power_reg == RUN) begin
      power_reg <= i_power_save_idle ? IDLE : SLEEP;  // see RQ21
      sleeping_reg <= !i_power_save_idle;
      idling_reg <= i_power_save_idle;
    end
  end

  // program counter load; wakes resume after the power-save instruction.
  // limitation: an interrupt wake reports the resume address; the core
  // substitutes its own vector when it takes the interrupt.
  // an interrupt seen while running loads nothing here.
  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      pc_reg <= rstcause_pkg::RESET_VEC;
      pc_load_reg <= 1'b0;
      sys_reset_reg <= 1'b0;
    end else begin
      sys_reset_reg <= any_reset;
      pc_load_reg <= any_reset | i_clkfail_evt | wdt_wake |
                     (i_irq_wake_evt & (power_reg != RUN));
      if (any_reset) begin
        pc_reg <= rstcause_pkg::RESET_VEC;  // see RQ1 see RQ11
      end else if (i_clkfail_evt) begin
        pc_reg <= rstcause_pkg::CLKFAIL_VEC;  // see RQ1
      end else if (wdt_wake || (i_irq_wake_evt && power_reg != RUN)) begin
        pc_reg <= i_cur_pc + rstcause_pkg::PC_STEP;  // see RQ9 see RQ10
      end
    end
  end

  // bus answer: one wait-free cycle, unmapped addresses read zero.
  // the ack term in the request decode stops a held strobe from being
  // taken twice; the master must drop cyc and stb before the next cycle.
  // read data is cleared when not acking so stale values never linger.
  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      ack_reg <= 1'b0;
      rdat_reg <= '0;
    end else begin
      ack_reg <= bus_req;
      rdat_reg <= '0;
      if (bus_req && !i_wb_we) begin
        unique case (i_wb_adr)
          rstcause_pkg::CTRL_OFS: rdat_reg <= {16'h0000, reset_control_reg};
          rstcause_pkg::FUSE_OFS: rdat_reg <= {31'h00000000, watchdog_config_word_reg};
          rstcause_pkg::PC_OFS: rdat_reg <= {8'h00, pc_reg};
          rstcause_pkg::WDT_OFS: rdat_reg <= {16'h0000, wdt_count_reg};
          default: rdat_reg <= '0;
        endcase
      end
    end
  end

  // outputs, each straight from its flop
  assign o_wb_ack = ack_reg;
  assign o_wb_dat = rdat_reg;
  assign o_pc_value = pc_reg;
  assign o_pc_load = pc_load_reg;
  assign o_sys_reset = sys_reset_reg;
  assign o_sleeping = sleeping_reg;
  assign o_idling = idling_reg;
  // detector control straight from register bits
  assign o_lowvolt_detect_enable = reset_control_reg[rstcause_pkg::LVEN_BIT];  // see RQ19
  assign o_lowvolt_level_sel = reset_control_reg[rstcause_pkg::LVL_LSB +: 4];  // see RQ18
  // pin is never pulled by internal resets
  assign o_master_clear_pin_out = 1'b0;  // see RQ22
  assign o_master_clear_pin_oe = 1'b0;   // see RQ22

endmodule // reset_cause_and_watchdog

// ===== verif/reset_cause_chk.sv
/*
  checker for reset_cause_and_watchdog: bus answer, vectors, power state.
  assumes events arrive as one-cycle pulses on i_clk and the pin is idle.
*/
`timescale 1ns/1ps
module reset_cause_chk (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [3:0] i_wb_sel,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic o_wb_ack,
  input wire logic i_por_evt,
  input wire logic i_bor_evt,
  input wire logic i_swr_evt,
  input wire logic i_trap_conflict_evt,
  input wire logic i_illegal_op_evt,
  input wire logic i_clkfail_evt,
  input wire logic i_irq_wake_evt,
  input wire logic i_power_save_instr,
  input wire logic i_power_save_idle,
  input wire logic [23:0] i_cur_pc,
  input wire logic o_master_clear_pin_out,
  input wire logic o_master_clear_pin_oe,
  input wire logic o_sys_reset,
  input wire logic o_pc_load,
  input wire logic [23:0] o_pc_value,
  input wire logic o_sleeping,
  input wire logic o_idling,
  input wire logic o_lowvolt_detect_enable,
  input wire logic [3:0] o_lowvolt_level_sel
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // no por, bor, soft, trap or illegal-op pulse, so wake and trap paths are unambiguous
  wire logic quiet;
  assign quiet = !(i_por_evt | i_bor_evt | i_swr_evt | i_trap_conflict_evt | i_illegal_op_evt);

  pin_undriven_a: assert property (!o_master_clear_pin_oe && !o_master_clear_pin_out)
    else $error("master clear pin driven");
  ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  ack_answer_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("bus request not answered next cycle");
  reset_vector_a: assert property (!quiet && !i_clkfail_evt |=>
    o_sys_reset && o_pc_load && o_pc_value == 24'h000000) else $error("reset vector wrong");
  clkfail_vector_a: assert property (i_clkfail_evt && quiet && !i_irq_wake_evt |=>
    o_pc_load && !o_sys_reset && o_pc_value == 24'h000004) else $error("clock fail vector wrong");
  lv_write_a: assert property (o_wb_ack && i_wb_we && i_wb_adr == 8'h00 && i_wb_sel[1] |=>
    o_lowvolt_detect_enable == $past(i_wb_dat[12]) && o_lowvolt_level_sel == $past(i_wb_dat[11:8]))
    else $error("detector controls not written");
  save_entry_a: assert property (i_power_save_instr && quiet |=>
    o_sleeping == !$past(i_power_save_idle) && o_idling == $past(i_power_save_idle))
    else $error("power save state wrong");
  irq_wake_a: assert property (o_sleeping && i_irq_wake_evt && quiet && !i_clkfail_evt |=>
    o_pc_load && !o_sys_reset && !o_sleeping && o_pc_value == $past(i_cur_pc) + 24'h000002)
    else $error("interrupt wake wrong");
endmodule // reset_cause_chk

bind reset_cause_and_watchdog reset_cause_chk u_chk (.*);

// ===== verif/tb_reset_cause_and_watchdog.sv
/*
  self-checking bench for reset_cause_and_watchdog over classic wishbone.
  assumes the register map and bit positions of rstcause_pkg.
*/
`timescale 1ns/1ps
module tb_reset_cause_and_watchdog;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, o_dat, rd;
  logic [6:0] evt = 7'h00;
  logic wclr = 1'b0, ps = 1'b0, ps_idle = 1'b0, pin_n = 1'b1, rc = 1'b0;
  logic [23:0] cur_pc = 24'h000120, pc_val;
  logic sys_rst, pc_ld, slp, idl, lv_en;
  logic [3:0] lv_lvl;
  int n_mismatch = 0, samples_checked = 0;
  // event order: por, bor, swr, trap, illegal, clkfail
  logic [15:0] set_m [6] = '{16'h0003, 16'h0002, 16'h0040, 16'h8000, 16'h4000, 16'h0000};
  logic [15:0] clr_m [6] = '{16'hC0DC, 16'h0001, 16'h009C, 16'h0000, 16'h0000, 16'h0000};
  logic [15:0] seeds [2] = '{16'h0000, 16'hC0DF};
  // expected flags after master clear in run, sleep, idle
  logic [15:0] master_clear_pin_x [3] = '{16'hC083, 16'hC0CB, 16'hC0C7};

  reset_cause_and_watchdog u_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_sel(4'hF), .i_wb_adr(adr), .i_wb_dat(wdat),
    .o_wb_dat(o_dat), .o_wb_ack(ack), .i_por_evt(evt[0]), .i_bor_evt(evt[1]),
    .i_swr_evt(evt[2]), .i_trap_conflict_evt(evt[3]), .i_illegal_op_evt(evt[4]),
    .i_clkfail_evt(evt[5]), .i_irq_wake_evt(evt[6]), .i_watchdog_clear_instr(wclr),
    .i_power_save_instr(ps), .i_power_save_idle(ps_idle), .i_cur_pc(cur_pc),
    .i_master_clear_pin_n(pin_n), .i_rc_tick(rc), .o_master_clear_pin_out(),
    .o_master_clear_pin_oe(), .o_sys_reset(sys_rst), .o_pc_load(pc_ld),
    .o_pc_value(pc_val), .o_sleeping(slp), .o_idling(idl),
    .o_lowvolt_detect_enable(lv_en), .o_lowvolt_level_sel(lv_lvl));

  always #4 i_clk = ~i_clk;

  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one classic cycle; read data is taken at the edge that samples ack
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge i_clk);
    for (int k = 0; k < 20 && ack !== 1'b1; k++) @(posedge i_clk);
    check("ack", ack, 1'b1);
    rd = o_dat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // outputs looked at one edge after the taking edge
  task pulse(input int k);
    @(posedge i_clk);
    evt <= 7'h01 << k;
    @(posedge i_clk);
    evt <= 7'h00;
    @(posedge i_clk);
  endtask

  task psave(input logic idle);
    @(posedge i_clk);
    ps <= 1'b1;
    ps_idle <= idle;
    @(posedge i_clk);
    ps <= 1'b0;
    @(posedge i_clk);
    check("sleeping", slp, !idle);
    check("idling", idl, idle);
  endtask

  // slow ticks so the two-flop synchroniser sees every edge
  task ticks(input int n);
    repeat (n) begin
      @(posedge i_clk);
      rc <= 1'b1;
      repeat (3) @(posedge i_clk);
      rc <= 1'b0;
      repeat (3) @(posedge i_clk);
    end
    repeat (4) @(posedge i_clk);
  endtask

  task finish_test;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #100000;
    n_mismatch++;
    finish_test;
  end

  initial begin
    repeat (6) @(posedge i_clk);
    i_rstn <= 1'b1;
    repeat (3) @(posedge i_clk);
    bus(0, 8'h00, 0); check("ctrl reset", rd, 32'h3);
    bus(0, 8'h04, 0); check("fuse reset", rd, 32'h1);
    bus(1, 8'h10, 32'hFFFFFFFF);
    bus(0, 8'h10, 0); check("unmapped", rd, 32'h0);
    bus(0, 8'h00, 0); check("ctrl kept", rd, 32'h3);
    // watchdog forced on by the erased fuse, then gated by the soft bit
    ticks(10);
    bus(0, 8'h0C, 0); check("wdt count", rd, 32'd10);
    @(posedge i_clk);
    wclr <= 1'b1;
    @(posedge i_clk);
    wclr <= 1'b0;
    bus(0, 8'h0C, 0); check("wdt cleared", rd, 32'h0);
    bus(1, 8'h04, 0);
    bus(0, 8'h04, 0); check("fuse off", rd, 32'h0);
    ticks(5);
    bus(0, 8'h0C, 0); check("wdt off", rd, 32'h0);
    bus(1, 8'h00, 32'h20);
    ticks(4);
    bus(0, 8'h0C, 0); check("wdt soft on", rd, 32'd4);
    // detector controls and the read-only settle flag
    bus(1, 8'h00, 32'hFFFF);
    bus(0, 8'h00, 0); check("ctrl all", rd, 32'hDFFF);
    check("lv en", lv_en, 1'b1);
    check("lv level", lv_lvl, 4'hF);
    repeat (130) @(posedge i_clk);
    bus(0, 8'h00, 0); check("settled", rd, 32'hFFFF);
    bus(1, 8'h00, 32'h0500);
    bus(0, 8'h00, 0); check("lv off", rd, 32'h0500);
    // por, bor, soft reset, trap, illegal op and clock-fail events against two starting flag patterns
    foreach (seeds[s]) for (int k = 0; k < 6; k++) begin
      bus(1, 8'h00, {16'h0, seeds[s]});
      pulse(k);
      check("pc", pc_val, (k == 5) ? 24'h4 : 24'h0);
      check("sys reset", sys_rst, k != 5);
      bus(0, 8'h00, 0);
      check("flags", rd, {16'h0, seeds[s] & ~clr_m[k] | set_m[k]});
    end
    // master clear while running, sleeping, idling
    for (int m = 0; m < 3; m++) begin
      bus(1, 8'h00, 32'hC0DF);
      if (m != 0) psave(m == 2);
      @(posedge i_clk);
      pin_n <= 1'b0;
      repeat (6) @(posedge i_clk);
      pin_n <= 1'b1;
      repeat (4) @(posedge i_clk);
      bus(0, 8'h00, 0); check("master_clear_pin flags", rd, {16'h0, master_clear_pin_x[m]});
    end
    // interrupt wake from sleep continues after the save instruction
    bus(1, 8'h00, 0);
    psave(1'b0);
    pulse(6);
    check("wake pc", pc_val, 24'h000122);
    check("awake", slp, 1'b0);
    bus(0, 8'h00, 0); check("wake flags", rd, 32'h8);
    finish_test;
  end
endmodule // tb_reset_cause_and_watchdog
